// ==== src/byte_fifo.v ====
// synchronous fifo with flush, valid and ready on both sides
`timescale 1ns/100ps
module byte_fifo #(
  parameter W = 8,
  parameter D = 8,
  parameter AW = 3
) (
  input wire mclk_i,
  input wire rst_i,
  input wire clr_i,
  input wire in_valid_i,
  output wire in_ready_o,
  input wire [W-1:0] in_data_i,
  output wire out_valid_o,
  input wire out_ready_i,
  output wire [W-1:0] out_data_o
);
  reg [W-1:0] mem [0:D-1];
  reg [AW-1:0] wp;
  reg [AW-1:0] rp;
  reg [AW:0] count;
  wire push;
  wire pop;

  assign in_ready_o = (count != D[AW:0]);
  assign out_valid_o = (count != {(AW+1){1'b0}});
  assign out_data_o = mem[rp];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  // storage has no reset; only the pointers and count need a defined value
  always @(posedge mclk_i) begin
    if (push) begin
      mem[wp] <= in_data_i;
    end
  end

  // pointers wrap naturally when depth is a power of two
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      wp <= {AW{1'b0}};
      rp <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else if (clr_i) begin
      wp <= {AW{1'b0}};
      rp <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wp <= wp + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        rp <= rp + {{(AW-1){1'b0}}, 1'b1};
      end
      if (push && !pop) begin
        count <= count + {{AW{1'b0}}, 1'b1};
      end else if (pop && !push) begin
        count <= count - {{AW{1'b0}}, 1'b1};
      end
    end
  end
endmodule // byte_fifo

// ==== src/serial_flash_read.v ====
// read-command front end of a serial flash, oversampling the host link
`timescale 1ns/100ps
`include "sflash_defs.vh"

// Contract
// - sample on rising, launch on falling clock
// - address counter increments per byte, wraps zero
// - basic read: opcode, three address bytes, data
// - chip select high ends read, stops driving
// - decode 03 basic, 0B fast read
// - fast read waits one dummy byte
// - reject fast/multi-lane reads during write cycle
// - dual output: single-lane address, eight dummies
// - dual address: two-lane address, four dummies
// - quad output: single address, eight dummies
// - quad address: four-lane address, six dummies
// - toggling indicator enters enhance mode
// - decode 3B dual output, BB dual address
// - decode 6B quad output, EB quad address
// - quad enable selects quad, disables protect (only EB and enhance reselect check it; 6B runs without it)
// - write in progress flag marks write cycle
// - enhance mode skips opcode after reselect
// - non-toggling indicator clears enhance mode
module serial_flash_read (
  input wire mclk_i,
  input wire rst_i,
  input wire cs_n_i,
  input wire sclk_i,
  input wire io_lane_zero_i,
  output reg io_lane_zero_o,
  output reg io_lane_zero_oe_o,
  input wire io_lane_one_i,
  output reg io_lane_one_o,
  output reg io_lane_one_oe_o,
  input wire io_lane_two_i,
  output reg io_lane_two_o,
  output reg io_lane_two_oe_o,
  input wire io_lane_three_i,
  output reg io_lane_three_o,
  output reg io_lane_three_oe_o,
  input wire write_in_progress_bit_i,
  input wire quad_enable_bit_i,
  output reg mem_req_o,
  output reg [`ADDR_W-1:0] mem_addr_o,
  input wire [7:0] mem_rdata_i,
  input wire mem_rvalid_i,
  output reg [`ADDR_W-1:0] rd_addr_o,
  output reg enhance_mode_o,
  output reg cmd_reject_o,
  output reg write_protect_active_o
);
  localparam S_IDLE = 3'h0;
  localparam S_CMD = 3'h1;
  localparam S_ADDR = 3'h2;
  localparam S_DUMMY = 3'h3;
  localparam S_DATA = 3'h4;
  localparam S_IGNORE = 3'h5;

  // two-stage synchronisers for every pin
  reg [5:0] pin_meta;
  reg [5:0] pin_sync;
  reg sclk_d;
  wire cs_s;
  wire sclk_s;
  wire [3:0] io_s;
  wire sclk_rise;
  wire sclk_fall;

  reg [2:0] state;
  reg [4:0] cnt;
  reg [6:0] opc;
  reg [`ADDR_W-1:0] addr;
  reg [1:0] a_sel;
  reg [1:0] d_sel;
  reg [4:0] dum_n;
  reg is_quad_io;
  reg [3:0] ind_hi;
  reg [7:0] sh;
  reg [2:0] step;
  reg first_byte;

  // prefetch side
  reg fetch_on;
  reg pending;
  reg stale;
  reg [`ADDR_W-1:0] fetch_addr;

  // decode results for the opcode being completed
  wire [7:0] cmd_byte;
  reg dec_known;
  reg dec_needs_idle;
  reg dec_needs_qe;
  reg [1:0] dec_a_sel;
  reg [1:0] dec_d_sel;
  reg [4:0] dec_dum;
  reg [`ADDR_W-1:0] addr_sh;
  reg [4:0] addr_last;
  reg [2:0] step_last;
  reg [3:0] oe_mask;
  reg [3:0] lane_bits;
  reg [7:0] cur_b;

  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [7:0] fifo_out;
  wire fifo_push;
  wire fifo_pop;
  wire addr_done;

  assign cs_s = pin_sync[5];
  assign sclk_s = pin_sync[4];
  assign io_s = pin_sync[3:0];
  // edges are found only on the second stage and its delayed copy
  assign sclk_rise = sclk_s && !sclk_d;
  assign sclk_fall = !sclk_s && sclk_d;
  assign cmd_byte = {opc, io_s[0]};
  assign addr_done = (state == S_ADDR) && sclk_rise && !cs_s && (cnt == addr_last);

  // pins are asynchronous to mclk, so nothing reads the first stage
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_meta <= 6'h3F;
      pin_sync <= 6'h3F;
      sclk_d <= 1'b1;
    end else begin
      pin_meta <= {cs_n_i, sclk_i, io_lane_three_i, io_lane_two_i,
                   io_lane_one_i, io_lane_zero_i};
      pin_sync <= pin_meta;
      sclk_d <= sclk_s;
    end
  end

  // opcode decode
  always @* begin
    dec_known = 1'b1;
    dec_needs_idle = 1'b1;
    dec_needs_qe = 1'b0;
    dec_a_sel = `LANES_1;
    dec_d_sel = `LANES_1;
    dec_dum = `DUMMY_NONE;
    case (cmd_byte)
      `OP_READ: begin
        dec_needs_idle = 1'b0;
      end
      `OP_FAST_READ: begin
        dec_dum = `DUMMY_FAST;
      end
      `OP_DUAL_OUTPUT_READ: begin
        dec_d_sel = `LANES_2;
        dec_dum = `DUMMY_FAST;
      end
      `OP_DUAL_LANE_ADDRESS_READ: begin
        dec_a_sel = `LANES_2;
        dec_d_sel = `LANES_2;
        dec_dum = `DUMMY_DUAL_IO;
      end
      `OP_QUAD_OUTPUT_READ: begin
        dec_d_sel = `LANES_4;
        dec_dum = `DUMMY_FAST;
      end
      `OP_QUAD_LANE_ADDRESS_READ: begin
        dec_needs_qe = 1'b1;
        dec_a_sel = `LANES_4;
        dec_d_sel = `LANES_4;
        dec_dum = `DUMMY_QUAD_IO;
      end
      default: begin
        dec_known = 1'b0;
      end
    endcase
  end

  // address shift, msb first with the top lane leading
  always @* begin
    case (a_sel)
      `LANES_2: begin
        addr_sh = {addr[`ADDR_W-3:0], io_s[1], io_s[0]};
        addr_last = `ADDR_LAST_2;
      end
      `LANES_4: begin
        addr_sh = {addr[`ADDR_W-5:0], io_s};
        addr_last = `ADDR_LAST_4;
      end
      default: begin
        addr_sh = {addr[`ADDR_W-2:0], io_s[0]};
        addr_last = `ADDR_LAST_1;
      end
    endcase
  end

  // output lane selection for the byte being shifted out
  always @* begin
    cur_b = (step == 3'h0) ? fifo_out : sh;
    case (d_sel)
      `LANES_2: begin
        step_last = `STEP_LAST_2;
        oe_mask = `OE_2;
        lane_bits = {2'h0, cur_b[7], cur_b[6]};
      end
      `LANES_4: begin
        step_last = `STEP_LAST_4;
        oe_mask = `OE_4;
        lane_bits = cur_b[7:4];
      end
      default: begin
        step_last = `STEP_LAST_1;
        oe_mask = `OE_1;
        lane_bits = {2'h0, cur_b[7], 1'b0};
      end
    endcase
  end

  // command sequencer: rising clock edges move the framing along
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= S_IDLE;
      cnt <= 5'h00;
      opc <= 7'h00;
      addr <= {`ADDR_W{1'b0}};
      a_sel <= `LANES_1;
      d_sel <= `LANES_1;
      dum_n <= `DUMMY_NONE;
      is_quad_io <= 1'b0;
      ind_hi <= 4'h0;
      enhance_mode_o <= 1'b0;
      cmd_reject_o <= 1'b0;
    end else if (cs_s) begin
      state <= S_IDLE;
      cnt <= 5'h00;
    end else begin
      case (state)
        S_IDLE: begin
          cnt <= 5'h00;
          cmd_reject_o <= 1'b0;
          if (enhance_mode_o) begin
            // reselect in enhance mode goes straight to address
            a_sel <= `LANES_4;
            d_sel <= `LANES_4;
            dum_n <= `DUMMY_QUAD_IO;
            is_quad_io <= 1'b1;
            if (write_in_progress_bit_i || !quad_enable_bit_i) begin
              state <= S_IGNORE;
              cmd_reject_o <= 1'b1;
            end else begin
              state <= S_ADDR;
            end
          end else begin
            state <= S_CMD;
          end
        end
        S_CMD: begin
          if (sclk_rise) begin
            opc <= cmd_byte[6:0];
            cnt <= cnt + 5'h01;
            if (cnt == 5'h07) begin
              cnt <= 5'h00;
              a_sel <= dec_a_sel;
              d_sel <= dec_d_sel;
              dum_n <= dec_dum;
              is_quad_io <= dec_needs_qe;
              if (cmd_byte == `OP_ENHANCE_RESET) begin
                enhance_mode_o <= 1'b0;
                state <= S_IGNORE;
              end else if (!dec_known) begin
                state <= S_IGNORE;
              end else if (dec_needs_idle && write_in_progress_bit_i) begin
                state <= S_IGNORE;
                cmd_reject_o <= 1'b1;
              end else if (dec_needs_qe && !quad_enable_bit_i) begin
                state <= S_IGNORE;
                cmd_reject_o <= 1'b1;
              end else begin
                state <= S_ADDR;
              end
            end
          end
        end
        S_ADDR: begin
          if (sclk_rise) begin
            addr <= addr_sh;
            cnt <= cnt + 5'h01;
            if (cnt == addr_last) begin
              cnt <= 5'h00;
              state <= (dum_n == `DUMMY_NONE) ? S_DATA : S_DUMMY;
            end
          end
        end
        S_DUMMY: begin
          if (sclk_rise) begin
            cnt <= cnt + 5'h01;
            // the first two quad dummies carry the enhance indicator
            if (is_quad_io && cnt == 5'h00) begin
              ind_hi <= io_s;
            end
            if (is_quad_io && cnt == 5'h01) begin
              enhance_mode_o <= ((ind_hi ^ io_s) == `ENH_TOGGLE);
            end
            if (cnt == dum_n - 5'h01) begin
              cnt <= 5'h00;
              state <= S_DATA;
            end
          end
        end
        S_DATA: begin
          state <= S_DATA;
        end
        S_IGNORE: begin
          state <= S_IGNORE;
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

  // data out: each falling clock edge launches the next lane group
  assign fifo_pop = (state == S_DATA) && !cs_s && sclk_fall && (step == 3'h0);

  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      sh <= 8'h00;
      step <= 3'h0;
      first_byte <= 1'b1;
      rd_addr_o <= {`ADDR_W{1'b0}};
      {io_lane_three_o, io_lane_two_o, io_lane_one_o, io_lane_zero_o} <= 4'h0;
      {io_lane_three_oe_o, io_lane_two_oe_o,
       io_lane_one_oe_o, io_lane_zero_oe_o} <= `OE_NONE;
    end else if (cs_s || state != S_DATA) begin
      // lanes float everywhere but the data phase
      {io_lane_three_oe_o, io_lane_two_oe_o,
       io_lane_one_oe_o, io_lane_zero_oe_o} <= `OE_NONE;
      step <= 3'h0;
      first_byte <= 1'b1;
      if (addr_done) begin
        rd_addr_o <= addr_sh;
      end
    end else if (sclk_fall) begin
      {io_lane_three_o, io_lane_two_o, io_lane_one_o, io_lane_zero_o} <= lane_bits;
      {io_lane_three_oe_o, io_lane_two_oe_o,
       io_lane_one_oe_o, io_lane_zero_oe_o} <= oe_mask;
      case (d_sel)
        `LANES_2: sh <= {cur_b[5:0], 2'h0};
        `LANES_4: sh <= {cur_b[3:0], 4'h0};
        default: sh <= {cur_b[6:0], 1'b0};
      endcase
      if (step == 3'h0) begin
        step <= step_last;
        first_byte <= 1'b0;
        if (!first_byte) begin
          rd_addr_o <= rd_addr_o + 24'h000001;
        end
      end else begin
        step <= step - 3'h1;
      end
    end
  end

  // prefetch: one read outstanding, issued only while the buffer has room
  assign fifo_push = mem_rvalid_i && pending && !stale && fetch_on;

  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      fetch_on <= 1'b0;
      pending <= 1'b0;
      stale <= 1'b0;
      fetch_addr <= {`ADDR_W{1'b0}};
      mem_req_o <= 1'b0;
      mem_addr_o <= {`ADDR_W{1'b0}};
    end else begin
      mem_req_o <= 1'b0;
      if (mem_rvalid_i) begin
        pending <= 1'b0;
        stale <= 1'b0;
      end
      if (cs_s) begin
        fetch_on <= 1'b0;
        // a reply still in flight belongs to the old frame
        if (pending && !mem_rvalid_i) begin
          stale <= 1'b1;
        end
      end else if (addr_done) begin
        fetch_on <= 1'b1;
        fetch_addr <= addr_sh;
      end else if (fetch_on && !pending && !mem_req_o && fifo_in_ready) begin
        mem_req_o <= 1'b1;
        mem_addr_o <= fetch_addr;
        // 24-bit counter rolls over to zero after the top address
        fetch_addr <= fetch_addr + 24'h000001;
        pending <= 1'b1;
      end
    end
  end

  // quad mode takes lane two away from write protect
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      write_protect_active_o <= 1'b0;
    end else begin
      write_protect_active_o <= !quad_enable_bit_i && !io_s[2];
    end
  end

  // prefetch buffer smooths memory latency against the serial rate
  byte_fifo #(
    .W(8),
    .D(`FIFO_DEPTH),
    .AW(`FIFO_AW)
  ) u_fifo (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .clr_i(cs_s),
    .in_valid_i(fifo_push),
    .in_ready_o(fifo_in_ready),
    .in_data_i(mem_rdata_i),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(fifo_pop),
    .out_data_o(fifo_out)
  );

  // an empty buffer at a byte boundary sends whatever word the
  // buffer read pointer shows; there is no stall on the link, so
  // the memory must answer well within one serial byte time
  // trade-off: a deeper buffer only helps after the first byte,
  // the first fetch latency is paid inside the dummy phase, or for 03 in the half clock after the last address bit
endmodule // serial_flash_read

// ==== src/sflash_defs.vh ====
// constants for the serial flash read front end
`ifndef SFLASH_DEFS_VH
`define SFLASH_DEFS_VH

// read opcodes
`define OP_READ 8'h03
`define OP_FAST_READ 8'h0B
`define OP_DUAL_OUTPUT_READ 8'h3B
`define OP_DUAL_LANE_ADDRESS_READ 8'hBB
`define OP_QUAD_OUTPUT_READ 8'h6B
`define OP_QUAD_LANE_ADDRESS_READ 8'hEB
`define OP_ENHANCE_RESET 8'hFF

// array address
`define ADDR_W 24

// lane width selects
`define LANES_1 2'h0
`define LANES_2 2'h1
`define LANES_4 2'h2

// last address clock index per lane width (24, 12, 6 clocks)
`define ADDR_LAST_1 5'h17
`define ADDR_LAST_2 5'h0B
`define ADDR_LAST_4 5'h05

// dummy clocks
`define DUMMY_NONE 5'h00
`define DUMMY_FAST 5'h08
`define DUMMY_DUAL_IO 5'h04
`define DUMMY_QUAD_IO 5'h06

// last output step of a byte per lane width
`define STEP_LAST_1 3'h7
`define STEP_LAST_2 3'h3
`define STEP_LAST_4 3'h1

// output enable masks, lane three down to lane zero
`define OE_NONE 4'h0
`define OE_1 4'h2
`define OE_2 4'h3
`define OE_4 4'hF

// enhance indicator: all upper bits toggle against lower bits
`define ENH_TOGGLE 4'hF

// prefetch buffer
`define FIFO_DEPTH 8
`define FIFO_AW 3

`endif

// ==== tb/flash_host_model.sv ====
// host controller model driving select, serial clock and lanes
`timescale 1ns/100ps
module flash_host_model (
  output reg cs_n_o,
  output reg sclk_o,
  input wire [3:0] dev_o_i,
  input wire [3:0] dev_oe_i,
  output wire [3:0] lane_o
);
  reg [3:0] hval;
  reg [3:0] hen;
  reg [3:0] flt;
  // undriven lanes wander, so a stale value can never pass for data
  assign lane_o = (dev_oe_i & dev_o_i) | (~dev_oe_i & hen & hval) | (~dev_oe_i & ~hen & flt);
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    hval = 4'h0;
    hen = 4'h0;
    flt = 4'hA;
  end
  // half-ns offset keeps link edges off the system clock edges
  task sel();
    #0.5 cs_n_o = 1'b0;
  endtask
  task desel();
    begin
      #80 cs_n_o = 1'b1;
      hen = 4'h0;
      #399.5;
    end
  endtask
  // n clocks on w lanes, top lane carries the msb of each group
  task send(input integer w, input integer n, input [31:0] v);
    integer k;
    begin
      hen = (w == 4) ? 4'hF : (w == 2) ? 4'h3 : 4'h1;
      for (k = n - 1; k >= 0; k = k - 1) begin
        hval = v >> (k * w);
        #80 sclk_o = 1'b1;
        #80 sclk_o = 1'b0;
      end
    end
  endtask
  task recv(input integer w, input integer n, output [31:0] v);
    integer k;
    begin
      hen = 4'h0;
      v = 32'h0;
      for (k = 0; k < n; k = k + 1) begin
        #80 sclk_o = 1'b1;
        v = (v << w) | ((w == 1) ? lane_o[1] : lane_o & ((1 << w) - 1));
        flt = ~flt;
        #80 sclk_o = 1'b0;
      end
    end
  endtask
endmodule // flash_host_model

// ==== tb/serial_flash_read_assertions.sv ====
// port checker for the serial flash read front end
`timescale 1ns/100ps
`include "sflash_defs.vh"
module serial_flash_read_assertions (
  input wire mclk_i,
  input wire rst_i,
  input wire cs_n_i,
  input wire write_in_progress_bit_i,
  input wire quad_enable_bit_i,
  input wire io_lane_zero_oe_o,
  input wire io_lane_one_oe_o,
  input wire io_lane_two_oe_o,
  input wire io_lane_three_oe_o,
  input wire mem_req_o,
  input wire [`ADDR_W-1:0] mem_addr_o,
  input wire cmd_reject_o,
  input wire write_protect_active_o
);
  reg [2:0] cs_hi;
  reg seen;
  reg [`ADDR_W-1:0] last_a;
  wire [3:0] oe;
  assign oe = {io_lane_three_oe_o, io_lane_two_oe_o, io_lane_one_oe_o, io_lane_zero_oe_o};
  // select sync lags a few clocks, so only a saturated count means surely idle
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      cs_hi <= 3'h0;
      seen <= 1'b0;
      last_a <= 24'h0;
    end else begin
      cs_hi <= !cs_n_i ? 3'h0 : (cs_hi == 3'h7) ? cs_hi : cs_hi + 3'h1;
      if (cs_hi == 3'h7)
        seen <= 1'b0;
      else if (mem_req_o)
        seen <= 1'b1;
      if (mem_req_o)
        last_a <= mem_addr_o;
    end
  end
  default clocking dck @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);
  AST_OE_IDLE: assert property (cs_hi == 3'h7 |-> oe == `OE_NONE)
    else $error("lanes driven while deselected");
  AST_OE_MASK: assert property (oe inside {`OE_NONE, `OE_1, `OE_2, `OE_4})
    else $error("lane enables not a legal group");
  AST_REQ_PULSE: assert property (mem_req_o |=> !mem_req_o)
    else $error("array request longer than one cycle");
  AST_ADDR_STEP: assert property (mem_req_o && seen |-> mem_addr_o == last_a + 24'h1)
    else $error("array address did not step by one");
  AST_OE_EARLY: assert property (!cs_n_i && !seen |-> oe == `OE_NONE)
    else $error("lanes driven before any fetch");
  AST_WP_QE: assert property (quad_enable_bit_i [*4] |-> !write_protect_active_o)
    else $error("protect pin active with quad enabled");
  AST_REJ_CAUSE: assert property ($rose(cmd_reject_o) |->
    $past(write_in_progress_bit_i) || !$past(quad_enable_bit_i))
    else $error("command refused without cause");
  AST_REJ_NOREQ: assert property (cmd_reject_o |-> !mem_req_o)
    else $error("refused command fetched data");
endmodule // serial_flash_read_assertions
bind serial_flash_read serial_flash_read_assertions i_serial_flash_read_assertions (.*);

// ==== tb/serial_flash_read_tb_top.sv ====
// self-checking bench for the serial flash read front end
`timescale 1ns/100ps
`include "sflash_defs.vh"
module serial_flash_read_tb_top;
  reg mclk_i = 1'b0;
  reg rst_i = 1'b1;
  reg write_in_progress_bit = 1'b0;
  reg qe = 1'b1;
  reg [7:0] mem_rdata_i = 8'h00;
  reg mem_rvalid_i = 1'b0;
  reg pend = 1'b0;
  reg [23:0] pa = 24'h0;
  reg [47:0] opl = 48'h030B3BBB6BEB;
  wire cs_n;
  wire sclk;
  wire [3:0] lane_in;
  wire [3:0] lane_out;
  wire [3:0] lane_oe;
  wire mem_req_o;
  wire [`ADDR_W-1:0] mem_addr_o;
  wire enhance_mode_o;
  wire [23:0] rd_addr;
  wire cmd_reject_o;
  integer seed = 32'hE38932A9;
  integer fail_count = 0;
  integer num_checks = 0;
  integer n_req = 0;
  integer cycles = 0;
  integer wait_k = 0;
  integer stall = 0;
  integer i;
  integer j;
  always #2 mclk_i = ~mclk_i;
  serial_flash_read i_serial_flash_read (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .cs_n_i(cs_n),
    .sclk_i(sclk),
    .io_lane_zero_i(lane_in[0]),
    .io_lane_zero_o(lane_out[0]),
    .io_lane_zero_oe_o(lane_oe[0]),
    .io_lane_one_i(lane_in[1]),
    .io_lane_one_o(lane_out[1]),
    .io_lane_one_oe_o(lane_oe[1]),
    .io_lane_two_i(lane_in[2]),
    .io_lane_two_o(lane_out[2]),
    .io_lane_two_oe_o(lane_oe[2]),
    .io_lane_three_i(lane_in[3]),
    .io_lane_three_o(lane_out[3]),
    .io_lane_three_oe_o(lane_oe[3]),
    .write_in_progress_bit_i(write_in_progress_bit),
    .quad_enable_bit_i(qe),
    .mem_req_o(mem_req_o),
    .mem_addr_o(mem_addr_o),
    .mem_rdata_i(mem_rdata_i),
    .mem_rvalid_i(mem_rvalid_i),
    .rd_addr_o(rd_addr),
    .enhance_mode_o(enhance_mode_o),
    .cmd_reject_o(cmd_reject_o),
    .write_protect_active_o()
  );
  flash_host_model i_flash_host_model (
    .cs_n_o(cs_n),
    .sclk_o(sclk),
    .dev_o_i(lane_out),
    .dev_oe_i(lane_oe),
    .lane_o(lane_in)
  );
  function [7:0] exp_byte(input [23:0] a);
    exp_byte = a[7:0] ^ a[15:8] ^ a[23:16] ^ 8'h5A;
  endfunction
  // array model: answers each request after a random 1 to 4 cycles
  initial forever begin
    @(posedge mclk_i);
    #1 mem_rvalid_i = 1'b0;
    if (pend && wait_k == 0) begin
      mem_rvalid_i = 1'b1;
      mem_rdata_i = exp_byte(pa);
      pend = 1'b0;
    end else if (pend)
      wait_k = wait_k - 1;
    if (mem_req_o === 1'b1) begin
      pend = 1'b1;
      pa = mem_addr_o;
      wait_k = $random(seed) & 3;
      n_req = n_req + 1;
    end
  end
  task check(input string nm, input [31:0] e, input [31:0] s);
    begin
      num_checks = num_checks + 1;
      if (s !== e) begin
        fail_count = fail_count + 1;
        $display("BAD %s expected %h seen %h", nm, e, s);
      end
    end
  endtask
  // one read: opcode unless skipped, address, indicator, dummies, nb bytes or a refusal
  task cmd(input [7:0] op, input [23:0] a, input [7:0] p, input integer nb,
           input integer skip, input integer r);
    integer aw;
    integer dw;
    integer dm;
    integer k;
    integer q;
    reg [31:0] v;
    reg [23:0] ea;
    begin
      ea = a + nb - 1;
      aw = (op == 8'hEB) ? 4 : (op == 8'hBB) ? 2 : 1;
      dw = (op == 8'h03 || op == 8'h0B) ? 1 : (op == 8'h3B || op == 8'hBB) ? 2 : 4;
      dm = (op == 8'h03) ? 0 : (aw > 1) ? 4 : 8;
      q = n_req;
      i_flash_host_model.sel();
      if (skip == 0)
        i_flash_host_model.send(1, 8, {24'h0, op});
      i_flash_host_model.send(aw, 24 / aw, {8'h0, a});
      if (aw == 4)
        i_flash_host_model.send(4, 2, {24'h0, p});
      i_flash_host_model.send(aw, dm, 32'h0);
      if (r) begin
        #400;
        check("reject flag", 1, cmd_reject_o);
        check("requests", q, n_req);
      end
      for (k = 0; k < nb && !r; k = k + 1) begin
        if (k == 1)
          #(stall);
        i_flash_host_model.recv(dw, 8 / dw, v);
        check("read byte", exp_byte(a + k), v);
      end
      if (nb > 0 && !r)
        check("read address", {8'h00, ea}, {8'h00, rd_addr});
      i_flash_host_model.desel();
    end
  endtask
  task end_of_test;
    begin
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  always @(posedge mclk_i) begin
    cycles = cycles + 1;
    if (cycles == 80000) begin
      fail_count = fail_count + 1;
      end_of_test();
    end
  end
  initial begin
    repeat (2) @(posedge mclk_i);
    #1 rst_i = 1'b0;
    repeat (4) @(posedge mclk_i);
    // every opcode at a random address, then across the top of the array
    for (i = 0; i < 12; i = i + 1) begin
      j = $random(seed);
      cmd(opl[47 - 8 * (i % 6) -: 8], (i < 6) ? j[23:0] : 24'hFFFFFE, 8'hFF, 3, 0, 0);
    end
    $display("opcode test done");
    @(posedge mclk_i);
    #1 write_in_progress_bit = 1'b1;
    for (i = 1; i < 6; i = i + 1)
      cmd(opl[47 - 8 * i -: 8], 24'h0, 8'hFF, 0, 0, 1);
    cmd(8'h03, 24'h000100, 8'hFF, 2, 0, 0);
    @(posedge mclk_i);
    #1 write_in_progress_bit = 1'b0;
    qe = 1'b0;
    cmd(8'hEB, 24'h0, 8'hFF, 0, 0, 1);
    @(posedge mclk_i);
    #1 qe = 1'b1;
    $display("refusal test done");
    cmd(8'hEB, 24'h00ABCD, 8'hA5, 2, 0, 0);
    check("enhance on", 1, enhance_mode_o);
    cmd(8'hEB, 24'h7FFFFF, 8'h0F, 2, 1, 0);
    check("enhance kept", 1, enhance_mode_o);
    cmd(8'hEB, 24'h123456, 8'hAA, 2, 1, 0);
    check("enhance off", 0, enhance_mode_o);
    cmd(8'h0B, 24'h00FF00, 8'h00, 2, 0, 0);
    $display("enhance test done");
    // select dropped inside the address: nothing may be fetched
    j = n_req;
    i_flash_host_model.sel();
    i_flash_host_model.send(1, 16, 32'h0300);
    i_flash_host_model.desel();
    check("short requests", j, n_req);
    // host stalls mid-stream so the buffer fills, then the stream resumes
    stall = 3000;
    cmd(8'h03, 24'hFFFFFA, 8'hFF, 12, 0, 0);
    stall = 0;
    $display("stall test done");
    end_of_test();
  end
endmodule // serial_flash_read_tb_top
